// *** core/fic_map.vh ***
// Operation
// - strobe: modifier, command, then four nibbles
// - command 0 clears unless address request
// - accumulator meaning set by command code
// - accept request: formatter reset, enable strobes
// - strobes need command 5, clear, request
// - select, rate, advance precede each strobe
// - first host: 16 bits, 4 parity, three
// - second host: 12 bits, 3 parity, five
// - length read bytewise and held
// - buffer clear plus five-bit serial parameter
// - grant after drop, one per 16 words
// - one 72-bit word per reference
// - data strobe decrements, forwards write strobe
// - relay forwards parameter, board stores word
// - final flag versus zero length mismatch errors
// - done needs zero, final flag, request
// - capture every reported sender error
// - both rates via half-rate indication
`ifndef FIC_MAP_VH
`define FIC_MAP_VH
// command codes
`define FIC_CMD_CLEAR   4'h0
`define FIC_CMD_ADDR_HI 4'h2
`define FIC_CMD_ADDR_LO 4'h3
`define FIC_CMD_LENGTH  4'h5
`define FIC_CMD_BUFSEL  4'hE
// index of the last accumulator nibble after the command
`define FIC_ACC_NIBBLES 2'h3
// strobes per host type
`define FIC_STB_TYPE0   3'h3
`define FIC_STB_TYPE1   3'h5
// index of the last word admitted per grant
`define FIC_GRANT_WORDS 4'hF
// serial parameter length
`define FIC_PARAM_BITS  3'h5
// register indexes on the plain port
`define FIC_REG_CTRL    2'h0
`define FIC_REG_STAT    2'h1
`define FIC_REG_LEN     2'h2
// control field positions and reset
`define FIC_CTRL_HOST   0
`define FIC_CTRL_HALF   1
`define FIC_CTRL_RST    2'h0
// timing
`define FIC_CLK_NS      10
`define FIC_CLEAR_NS    60
`define FIC_CLEAR_CYC   4'h6
`define FIC_DIV_FULL    4'h6
`define FIC_DIV_HALF    4'hC
`endif

// *** core/fic_address_formatter.v ***
`timescale 1ns/100ps
`default_nettype none
`include "fic_map.vh"
module fic_address_formatter (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // accumulator load
  input  wire        acc_load,
  input  wire [3:0]  acc_cmd,
  input  wire [15:0] acc_data,
  // sequencing
  input  wire        fmt_reset,
  input  wire        fmt_advance,
  input  wire        host_type,
  input  wire        len_sel,
  // outputs
  output reg  [15:0] field_out,
  output reg  [3:0]  parity_out,
  output wire [7:0]  len_byte,
  output wire [4:0]  buf_param
);
  reg  [15:0] addr_hi_reg;  // upper address half
  reg  [15:0] addr_lo_reg;  // lower address half
  reg  [15:0] blen_reg;     // block length
  reg  [4:0]  bufsel_reg;   // pointer bit and buffer number
  reg  [2:0]  rd_cnt_reg;   // address readout counter
  reg  [15:0] field_next;   // next field to present
  wire [3:0]  par_next;     // parity of next field

  assign len_byte  = len_sel ? blen_reg[15:8] : blen_reg[7:0];
  assign buf_param = bufsel_reg;

  // accumulator capture by command
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_hi_reg <= 16'h0000;
      addr_lo_reg <= 16'h0000;
      blen_reg    <= 16'h0000;
      bufsel_reg  <= 5'h00;
    end else if (acc_load) begin
      case (acc_cmd)
        `FIC_CMD_LENGTH:  blen_reg <= acc_data;
        `FIC_CMD_ADDR_HI: addr_hi_reg <= acc_data;
        `FIC_CMD_ADDR_LO: addr_lo_reg <= acc_data;
        `FIC_CMD_BUFSEL:  bufsel_reg <= acc_data[4:0];
        default:          bufsel_reg <= bufsel_reg;
      endcase
    end
  end

  // field selection per readout count
  always @* begin
    field_next = 16'h0000;
    if (!host_type) begin
      case (rd_cnt_reg)
        3'h0:    field_next = addr_hi_reg;
        3'h1:    field_next = addr_lo_reg;
        3'h2:    field_next = blen_reg;
        default: field_next = 16'h0000;
      endcase
    end else begin
      case (rd_cnt_reg)
        3'h0:    field_next = {4'h0, addr_lo_reg[11:0]};
        3'h1:    field_next = {4'h0, addr_hi_reg[7:0], addr_lo_reg[15:12]};
        3'h2:    field_next = {8'h00, addr_hi_reg[15:8]};
        3'h3:    field_next = {4'h0, blen_reg[11:0]};
        3'h4:    field_next = {12'h000, blen_reg[15:12]};
        default: field_next = 16'h0000;
      endcase
    end
  end

  // odd parity per nibble, top nibble unused on second host type
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_par
      assign par_next[gi] = (host_type && gi == 3) ? 1'b0 : ~^field_next[gi*4 +: 4];
    end
  endgenerate

  // readout counter and output field
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_cnt_reg <= 3'h0;
      field_out  <= 16'h0000;
      parity_out <= 4'h0;
    end else if (fmt_reset) begin
      rd_cnt_reg <= 3'h0;
    end else if (fmt_advance) begin
      field_out  <= field_next;
      parity_out <= par_next;
      rd_cnt_reg <= rd_cnt_reg + 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** core/fic_input_controller.v ***
`timescale 1ns/100ps
`default_nettype none
`include "fic_map.vh"
module fic_input_controller #(
  parameter LEN_W = 16
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // io processor function port
  input  wire             function_strobe,
  input  wire [3:0]       function_data,
  // register port
  input  wire [1:0]       reg_addr,
  input  wire [15:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [15:0]      reg_rdata,
  // remote sender link
  input  wire             addr_request,
  input  wire             data_strobe,
  input  wire [71:0]      data_word,
  input  wire             final_word,
  input  wire             err_addr_parity,
  input  wire             err_secded,
  input  wire             err_sequence,
  input  wire             err_length,
  output reg              channel_clear,
  output reg              addr_strobe,
  output wire [15:0]      addr_field,
  output wire [3:0]       addr_parity,
  output reg              data_grant,
  // buffer board
  output reg              buf_clear,
  output reg              param_serial,
  output reg              word_write,
  output reg  [71:0]      word_out,
  output reg              pointer_a_sel,
  output reg              half_rate_mode,
  // status
  output reg              done_flag,
  output reg              fatal_error
);
  // function decode states
  localparam F_IDLE = 2'h0;
  localparam F_CMD  = 2'h1;
  localparam F_ACC  = 2'h2;
  // channel states
  localparam S_IDLE  = 4'h0;
  localparam S_CLEAR = 4'h1;
  localparam S_RST   = 4'h2;
  localparam S_LEN   = 4'h3;
  localparam S_ADV   = 4'h4;
  localparam S_STB   = 4'h5;
  localparam S_DROP  = 4'h6;
  localparam S_GRANT = 4'h7;
  localparam S_XFER  = 4'h8;
  localparam S_END   = 4'h9;

  reg  [1:0]       f_state_reg;   // function decode state
  reg  [3:0]       cmd_reg;       // latched command code
  reg              modifier_reg;  // latched modifier bit
  reg  [1:0]       nib_cnt_reg;   // accumulator nibble count
  reg  [15:0]      acc_reg;       // accumulator assembly
  reg              acc_load;      // accumulator complete pulse
  reg              cmd0_evt;      // command 0 decoded pulse
  reg              cmd5_evt;      // command 5 complete pulse
  reg              cmd5_pend_reg; // command 5 awaiting start
  reg              clr_done_reg;  // clear sequence finished
  reg  [3:0]       state_reg;     // channel state
  reg  [3:0]       clr_cnt_reg;   // clear pulse countdown
  reg  [2:0]       stb_cnt_reg;   // address strobes sent
  reg  [LEN_W-1:0] len_reg;       // held block length
  reg  [3:0]       grp_cnt_reg;   // words in current grant
  reg              final_reg;     // final word flag seen
  reg  [4:0]       par_sh_reg;    // serial parameter shifter
  reg  [2:0]       par_cnt_reg;   // serial bits remaining
  reg  [3:0]       err_reg;       // captured sender errors
  reg  [1:0]       ctrl_reg;      // host type and rate
  reg  [3:0]       div_cnt_reg;   // strobe pacing divider
  reg              tick;          // pacing enable pulse
  reg              fmt_reset;     // formatter reset pulse
  reg              fmt_advance;   // formatter advance pulse
  reg              len_sel;       // length byte select
  wire [7:0]       len_byte;      // length byte from formatter
  wire [4:0]       buf_param;     // buffer parameter bits
  wire [2:0]       stb_total;     // strobes for host type
  wire             last_word;     // this strobe ends the block
  wire             xfer_strobe;   // strobe while transferring

  assign stb_total   = ctrl_reg[`FIC_CTRL_HOST] ? `FIC_STB_TYPE1 : `FIC_STB_TYPE0;
  assign last_word   = (len_reg == {{(LEN_W-1){1'b0}}, 1'b1});
  assign xfer_strobe = (state_reg == S_XFER) && data_strobe;

  // address and length formatter
  fic_address_formatter u_fmt (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .acc_load    (acc_load),
    .acc_cmd     (cmd_reg),
    .acc_data    (acc_reg),
    .fmt_reset   (fmt_reset),
    .fmt_advance (fmt_advance),
    .host_type   (ctrl_reg[`FIC_CTRL_HOST]),
    .len_sel     (len_sel),
    .field_out   (addr_field),
    .parity_out  (addr_parity),
    .len_byte    (len_byte),
    .buf_param   (buf_param)
  );

  // function strobe decode
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      f_state_reg  <= F_IDLE;
      cmd_reg      <= 4'h0;
      modifier_reg <= 1'b0;
      nib_cnt_reg  <= 2'h0;
      acc_reg      <= 16'h0000;
      acc_load     <= 1'b0;
      cmd0_evt     <= 1'b0;
      cmd5_evt     <= 1'b0;
    end else begin
      acc_load <= 1'b0;
      cmd0_evt <= 1'b0;
      cmd5_evt <= 1'b0;
      case (f_state_reg)
        F_IDLE: begin
          if (function_strobe) begin
            modifier_reg <= function_data[0];
            f_state_reg  <= F_CMD;
          end
        end
        F_CMD: begin
          cmd_reg     <= function_data;
          nib_cnt_reg <= 2'h0;
          if (function_data == `FIC_CMD_CLEAR) begin
            cmd0_evt    <= 1'b1;
            f_state_reg <= F_IDLE;
          end else if (function_data == `FIC_CMD_LENGTH ||
                       function_data == `FIC_CMD_ADDR_HI ||
                       function_data == `FIC_CMD_ADDR_LO ||
                       function_data == `FIC_CMD_BUFSEL) begin
            f_state_reg <= F_ACC;
          end else begin
            f_state_reg <= F_IDLE;
          end
        end
        F_ACC: begin
          acc_reg     <= {acc_reg[11:0], function_data};
          nib_cnt_reg <= nib_cnt_reg + 2'h1;
          if (nib_cnt_reg == `FIC_ACC_NIBBLES) begin
            acc_load    <= 1'b1;
            cmd5_evt    <= (cmd_reg == `FIC_CMD_LENGTH);
            f_state_reg <= F_IDLE;
          end
        end
        default: f_state_reg <= F_IDLE;
      endcase
    end
  end

  // strobe pacing divider, slower in half-rate mode
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 4'h0;
      tick        <= 1'b0;
    end else begin
      if (div_cnt_reg == 4'h0) begin
        div_cnt_reg <= ctrl_reg[`FIC_CTRL_HALF] ? (`FIC_DIV_HALF - 4'h1) : (`FIC_DIV_FULL - 4'h1);
        tick        <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg - 4'h1;
        tick        <= 1'b0;
      end
    end
  end

  // channel sequencer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      cmd5_pend_reg <= 1'b0;
      clr_done_reg  <= 1'b0;
      clr_cnt_reg   <= 4'h0;
      stb_cnt_reg   <= 3'h0;
      len_reg       <= {LEN_W{1'b0}};
      grp_cnt_reg   <= 4'h0;
      final_reg     <= 1'b0;
      channel_clear <= 1'b0;
      addr_strobe   <= 1'b0;
      data_grant    <= 1'b0;
      buf_clear     <= 1'b0;
      word_write    <= 1'b0;
      word_out      <= 72'h00_0000_0000_0000_0000;
      pointer_a_sel <= 1'b0;
      done_flag     <= 1'b0;
      fatal_error   <= 1'b0;
      fmt_reset     <= 1'b0;
      fmt_advance   <= 1'b0;
      len_sel       <= 1'b0;
    end else begin
      addr_strobe <= 1'b0;
      data_grant  <= 1'b0;
      buf_clear   <= 1'b0;
      word_write  <= 1'b0;
      fmt_reset   <= 1'b0;
      fmt_advance <= 1'b0;
      if (cmd5_evt) begin
        cmd5_pend_reg <= 1'b1;
        done_flag   <= 1'b0;
        fatal_error <= 1'b0;
      end
      if (cmd0_evt) begin
        cmd5_pend_reg <= 1'b0;
        done_flag     <= 1'b0;
        fatal_error   <= 1'b0;
        if (!addr_request) begin
          clr_done_reg  <= 1'b0;
          clr_cnt_reg   <= `FIC_CLEAR_CYC;
          channel_clear <= 1'b1;
          state_reg     <= S_CLEAR;
        end else begin
          clr_done_reg <= 1'b1;
          state_reg    <= S_IDLE;
        end
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (cmd5_pend_reg && clr_done_reg && addr_request) begin
              cmd5_pend_reg <= 1'b0;
              fmt_reset     <= 1'b1;
              buf_clear     <= 1'b1;
              pointer_a_sel <= ~buf_param[4];
              stb_cnt_reg   <= 3'h0;
              final_reg     <= 1'b0;
              len_sel       <= 1'b0;
              state_reg     <= S_RST;
            end
          end
          S_CLEAR: begin
            if (clr_cnt_reg == 4'h1) begin
              channel_clear <= 1'b0;
              clr_done_reg  <= 1'b1;
              state_reg     <= S_IDLE;
            end
            clr_cnt_reg <= clr_cnt_reg - 4'h1;
          end
          S_RST: begin
            len_reg[7:0] <= len_byte;
            len_sel      <= 1'b1;
            state_reg    <= S_LEN;
          end
          S_LEN: begin
            len_reg[LEN_W-1:8] <= len_byte[LEN_W-9:0];
            len_sel            <= 1'b0;
            state_reg          <= S_ADV;
          end
          S_ADV: begin
            if (tick) begin
              fmt_advance <= 1'b1;
              state_reg   <= S_STB;
            end
          end
          S_STB: begin
            addr_strobe <= 1'b1;
            stb_cnt_reg <= stb_cnt_reg + 3'h1;
            if (stb_cnt_reg + 3'h1 == stb_total) begin
              state_reg <= S_DROP;
            end else begin
              state_reg <= S_ADV;
            end
          end
          S_DROP: begin
            if (!addr_request) begin
              state_reg <= S_GRANT;
            end
          end
          S_GRANT: begin
            data_grant  <= 1'b1;
            grp_cnt_reg <= 4'h0;
            state_reg   <= S_XFER;
          end
          S_XFER: begin
            if (xfer_strobe) begin
              len_reg     <= len_reg - {{(LEN_W-1){1'b0}}, 1'b1};
              word_write  <= 1'b1;
              word_out    <= data_word;
              grp_cnt_reg <= grp_cnt_reg + 4'h1;
              final_reg   <= final_word;
              if (final_word != last_word) begin
                fatal_error <= 1'b1;
              end
              if (last_word || final_word) begin
                state_reg <= S_END;
              end else if (grp_cnt_reg == `FIC_GRANT_WORDS) begin
                state_reg <= S_GRANT;
              end
            end
          end
          S_END: begin
            if (len_reg == {LEN_W{1'b0}} && final_reg && addr_request) begin
              done_flag <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // serial parameter relay to buffer board
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      par_sh_reg   <= 5'h00;
      par_cnt_reg  <= 3'h0;
      param_serial <= 1'b0;
    end else if (state_reg == S_IDLE && fmt_reset) begin
      par_sh_reg  <= 5'h00;
    end else if (state_reg == S_RST) begin
      par_sh_reg  <= buf_param;
      par_cnt_reg <= `FIC_PARAM_BITS;
    end else if (par_cnt_reg != 3'h0) begin
      param_serial <= par_sh_reg[0];
      par_sh_reg   <= {1'b0, par_sh_reg[4:1]};
      par_cnt_reg  <= par_cnt_reg - 3'h1;
    end else begin
      param_serial <= xfer_strobe;
    end
  end

  // sticky sender error capture, set wins over clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_reg <= 4'h0;
    end else begin
      err_reg <= ((cmd0_evt || cmd5_evt) ? 4'h0 : err_reg) |
                 {err_length, err_sequence, err_secded, err_addr_parity};
    end
  end

  // control register and read port
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg       <= `FIC_CTRL_RST;
      half_rate_mode <= 1'b0;
      reg_rdata      <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `FIC_REG_CTRL) begin
        ctrl_reg <= reg_wdata[1:0];
      end
      half_rate_mode <= ctrl_reg[`FIC_CTRL_HALF];
      reg_rdata      <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `FIC_REG_CTRL: reg_rdata <= {14'h0000, ctrl_reg};
          `FIC_REG_STAT: reg_rdata <= {state_reg, 4'h0, err_reg, modifier_reg,
                                       clr_done_reg, fatal_error, done_flag};
          `FIC_REG_LEN:  reg_rdata <= len_reg;
          default:       reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/fic_sender_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fic_sender_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // from the channel
  input  wire logic        channel_clear,
  input  wire logic        addr_strobe,
  input  wire logic        data_grant,
  // scenario controls
  input  wire logic        host_type,
  input  wire logic        early,
  input  wire logic [15:0] n_words,
  input  wire logic [3:0]  err_in,
  // to the channel
  output logic             addr_request,
  output logic             data_strobe,
  output logic [71:0]      data_word,
  output logic             final_word,
  output wire logic        err_addr_parity,
  output wire logic        err_secded,
  output wire logic        err_sequence,
  output wire logic        err_length
);
  logic [2:0]  stb_cnt; // address strobes taken
  logic [7:0]  credit;  // granted words not yet sent
  logic [15:0] sent;    // words sent this block
  logic [2:0]  gap;     // word pacing
  logic        xfer;    // data phase
  logic        go;      // send a word now
  logic        last;    // flagged word
  assign {err_length, err_sequence, err_secded, err_addr_parity} = err_in;
  assign go = xfer && (credit != 8'h00) && (gap == 3'h5);
  assign last = sent == n_words - (early ? 16'h0003 : 16'h0001);
  // sender sequencing
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_request <= 1'b0;
      data_strobe <= 1'b0;
      final_word <= 1'b0;
      data_word <= 72'h0;
      stb_cnt <= 3'h0;
      credit <= 8'h00;
      sent <= 16'h0000;
      gap <= 3'h0;
      xfer <= 1'b0;
    end else begin
      // one strobe per word, lines wander otherwise
      data_strobe <= go;
      data_word <= go ? {8'hC3, 48'h0, sent} : ~data_word;
      // flag rides on the last strobe
      final_word <= go && last;
      gap <= (gap == 3'h5) ? 3'h0 : gap + 3'h1;
      credit <= credit + (data_grant ? 8'h10 : 8'h00) - (go ? 8'h01 : 8'h00);
      if (addr_strobe) begin
        stb_cnt <= stb_cnt + 3'h1;
      end
      if (channel_clear) begin
        addr_request <= 1'b1;
        stb_cnt <= 3'h0;
        credit <= 8'h00;
        xfer <= 1'b0;
      end else if (addr_request && stb_cnt == (host_type ? 3'h5 : 3'h3)) begin
        addr_request <= 1'b0;
        stb_cnt <= 3'h0;
        credit <= 8'h00;
        xfer <= 1'b1;
        sent <= 16'h0000;
      end else if (go) begin
        sent <= sent + 16'h0001;
        if (last) begin
          xfer <= 1'b0;
          addr_request <= !early;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/fic_input_controller_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module fic_input_controller_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // function port
  input wire logic       function_strobe,
  input wire logic [3:0] function_data,
  // link
  input wire logic       addr_request,
  input wire logic       data_strobe,
  input wire logic       channel_clear,
  input wire logic       addr_strobe,
  input wire logic       data_grant,
  // board and status
  input wire logic       buf_clear,
  input wire logic       word_write,
  input wire logic       half_rate_mode,
  input wire logic       done_flag,
  input wire logic       fatal_error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_clear_six: assert property (
    $rose(channel_clear) |-> channel_clear[*6] ##1 !channel_clear) else $error("clear length");
  a_clear_start: assert property (
    function_strobe ##1 (function_data == 4'h0 && !addr_request) |-> ##[1:3] channel_clear)
    else $error("clear missing");
  a_clear_skip: assert property (
    function_strobe ##1 (function_data == 4'h0 && addr_request) |-> ##1 !channel_clear[*4])
    else $error("clear not skipped");
  a_strobe_gap: assert property (
    addr_strobe |=> !addr_strobe[*5]) else $error("strobes too close");
  a_half_gap: assert property (
    addr_strobe && half_rate_mode |=> !addr_strobe[*8]) else $error("half rate pacing");
  a_bufclr_lead: assert property (
    $rose(buf_clear) |-> ##[2:20] addr_strobe) else $error("no strobe after clear");
  a_grant_dropped: assert property (
    data_grant |-> !addr_request) else $error("grant with request");
  a_grant_follows: assert property (
    $fell(addr_request) |-> ##[1:3] data_grant) else $error("grant late");
  a_write_cause: assert property (
    word_write |-> $past(data_strobe)) else $error("write without strobe");
  a_fatal_cause: assert property (
    $rose(fatal_error) |-> $past(data_strobe)) else $error("fatal without strobe");
  a_done_cause: assert property (
    $rose(done_flag) |-> $past(addr_request)) else $error("done without request");
endmodule
bind fic_input_controller fic_input_controller_monitor fic_input_controller_monitor_i (
  .clk_sys, .rst, .function_strobe, .function_data, .addr_request, .data_strobe,
  .channel_clear, .addr_strobe, .data_grant, .buf_clear, .word_write,
  .half_rate_mode, .done_flag, .fatal_error);
`default_nettype wire

// *** bench/tb_fic_input_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_fic_input_controller;
  logic clk_sys = 1'b0, rst, function_strobe, reg_wr, reg_rd, host_type, early;
  logic [3:0] function_data, err_in, addr_parity, par [0:7];
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, n_words, reg_rdata, addr_field, v, fld [0:7];
  logic addr_request, data_strobe, final_word, err_addr_parity, err_secded, err_sequence;
  logic err_length, channel_clear, addr_strobe, data_grant, buf_clear, param_serial;
  logic word_write, pointer_a_sel, half_rate_mode, done_flag, fatal_error;
  logic [71:0] data_word, word_out;
  logic [5:0] ps; // serial parameter capture
  integer num_errors = 0, check_count = 0, n_clr, n_grant, sc, wcnt, pc;
  fic_input_controller fic_input_controller_i (.clk_sys, .rst, .function_strobe,
    .function_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .addr_request,
    .data_strobe, .data_word, .final_word, .err_addr_parity, .err_secded, .err_sequence,
    .err_length, .channel_clear, .addr_strobe, .addr_field, .addr_parity, .data_grant,
    .buf_clear, .param_serial, .word_write, .word_out, .pointer_a_sel, .half_rate_mode,
    .done_flag, .fatal_error);
  fic_sender_model fic_sender_model_i (.clk_sys, .rst, .channel_clear, .addr_strobe,
    .data_grant, .host_type, .early, .n_words, .err_in, .addr_request, .data_strobe,
    .data_word, .final_word, .err_addr_parity, .err_secded, .err_sequence, .err_length);
  // clock
  always #5 clk_sys = ~clk_sys;
  task check(input logic [71:0] seen, input logic [71:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // odd parity per nibble
  function logic [3:0] odd4(input logic [15:0] f);
    odd4 = {~^f[15:12], ~^f[11:8], ~^f[7:4], ~^f[3:0]};
  endfunction
  // link and board observers
  always @(posedge clk_sys) begin
    if (channel_clear === 1'b1) n_clr <= n_clr + 1;
    if (data_grant === 1'b1) n_grant <= n_grant + 1;
    if (addr_strobe === 1'b1) begin
      fld[sc[2:0]] <= addr_field;
      par[sc[2:0]] <= addr_parity;
      sc <= sc + 1;
    end
    if (pc != 0 && pc <= 5) ps <= {param_serial, ps[5:1]};
    pc <= (buf_clear === 1'b1) ? 6 : (pc != 0) ? pc - 1 : 0;
    if (word_write === 1'b1) begin
      check(word_out, {8'hC3, 48'h0, wcnt[15:0]});
      check(param_serial, 1'b1);
      wcnt <= wcnt + 1;
    end
  end
  task wr(input logic [1:0] a, input logic [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input logic [1:0] a, output logic [15:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
      @(posedge clk_sys);
    end
  endtask
  // strobe with modifier, command, then nibbles high first
  task fn(input logic [3:0] c, input logic [15:0] d);
    integer i;
    begin
      function_strobe <= 1'b1;
      function_data <= 4'h1;
      @(posedge clk_sys);
      function_strobe <= 1'b0;
      function_data <= c;
      @(posedge clk_sys);
      for (i = 3; i >= 0 && c != 4'h0; i = i - 1) begin
        function_data <= d[4*i+:4];
        @(posedge clk_sys);
      end
      function_data <= 4'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // one block: address, length, words, then field checks
  task xfer(input logic [15:0] hi, lo, len, input logic ht, hr, input integer nw);
    integer i, k;
    logic [15:0] e [0:4];
    logic [3:0] p;
    begin
      wr(2'h0, {14'h0, hr, ht});
      host_type <= ht;
      n_words <= len;
      sc = 0;
      wcnt = 0;
      n_grant = 0;
      fn(4'h2, hi);
      fn(4'h3, lo);
      fn(4'h5, len);
      for (k = 0; k < 3000 && done_flag !== 1'b1 && fatal_error !== 1'b1; k = k + 1)
        @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      e[0] = ht ? {4'h0, lo[11:0]} : hi;
      e[1] = ht ? {4'h0, hi[7:0], lo[15:12]} : lo;
      e[2] = ht ? {8'h0, hi[15:8]} : len;
      e[3] = {4'h0, len[11:0]};
      e[4] = {12'h0, len[15:12]};
      check(sc, ht ? 5 : 3);
      for (i = 0; i < (ht ? 5 : 3); i = i + 1) begin
        p = odd4(e[i]);
        check(fld[i], e[i]);
        check(par[i], ht ? {1'b0, p[2:0]} : p);
      end
      check(wcnt, nw);
      check(n_grant, (nw + 15) / 16);
    end
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors = num_errors + 1;
    summarize;
  end
  initial begin
    {rst, function_strobe, function_data, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 25'h0};
    {host_type, early, n_words, err_in, n_clr, n_grant, sc, wcnt, pc, ps} = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(2'h0, v);
    check(v, 16'h0000);
    rd(2'h3, v);
    check(v, 16'h0000);
    fn(4'h0, 16'h0000);
    repeat (8) @(posedge clk_sys);
    check(n_clr, 6);
    // pointer bit set, buffer ten
    fn(4'hE, 16'h001A);
    xfer(16'h1234, 16'hABCD, 16'h0014, 1'b0, 1'b0, 20);
    check({done_flag, fatal_error}, 2'b10);
    check(ps[5:1], 5'b11010);
    check(pointer_a_sel, 1'b0);
    n_clr = 0;
    fn(4'h0, 16'h0000);
    repeat (8) @(posedge clk_sys);
    check(n_clr, 0);
    xfer(16'h5A5A, 16'h0F0F, 16'h0003, 1'b1, 1'b1, 3);
    check(half_rate_mode, 1'b1);
    check({done_flag, fatal_error}, 2'b10);
    early <= 1'b1;
    xfer(16'h0001, 16'h0002, 16'h0006, 1'b0, 1'b0, 4);
    check({done_flag, fatal_error}, 2'b01);
    err_in <= 4'hF;
    @(posedge clk_sys);
    err_in <= 4'h0;
    rd(2'h1, v);
    check(v[7:4], 4'hF);
    check(v[1:0], 2'b10);
    early <= 1'b0;
    fn(4'h0, 16'h0000);
    repeat (8) @(posedge clk_sys);
    rd(2'h1, v);
    check(v & 16'h00FF, 16'h000C);
    summarize;
  end
endmodule
`default_nettype wire
